// >>> src/aof_pkg.sv
// constants for the converter output formatting stage
// assumes one system clock; serial port pins are synchronous to it
// Summary of operation
// [RULE1] test field 000 passes conversion results
// [RULE2] test field 001 forces all outputs zero
// [RULE3] test field 011 forces all outputs one
// [RULE4] test field 101 alternates checkerboard words
// [RULE5] test field 111 toggles all-zero, all-one
// [RULE6] software programs only the five listed codes
// [RULE7] bit 1 turns output randomizer on
// [RULE8] bit 0 selects two's complement output
// [RULE9] alternate polarity forces offset binary output
// [RULE10] bits 7 and 6 are ignored
// [RULE11] serial word: flag, address, data, sixteen edges
// [RULE12] read returns register, leaves it unchanged
// [RULE13] software reset clears format register
// [RULE14] test patterns bypass all data formatting
// [RULE15] new format applies from next output word
package aof_pkg;
    localparam int DATA_W = 12;
    localparam int WORD_W = DATA_W + 1;
    // serial port layout
    localparam logic [4:0] SER_BITS = 5'h10;
    localparam logic [4:0] SER_CMD_LAST = 5'h07;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [6:0] ADDR_FORMAT = 7'h04;
    localparam int RESET_BIT = 7;
    localparam logic [7:0] FORMAT_RESET = 8'h00;
    localparam logic [7:0] FORMAT_USED_MASK = 8'h3F;
    // format register fields
    localparam int TP_LSB = 3;
    localparam int TP_W = 3;
    localparam int ABP_BIT = 2;
    localparam int OUTPUT_SCRAMBLE_ENABLE_BIT = 1;
    localparam int TWOS_BIT = 0;
    localparam logic [2:0] TP_OFF = 3'h0;
    localparam logic [2:0] TP_ZERO = 3'h1;
    localparam logic [2:0] TP_ONES = 3'h3;
    localparam logic [2:0] TP_CHECKER = 3'h5;
    localparam logic [2:0] TP_TOGGLE = 3'h7;
    // pattern words, overrange flag in the top bit
    localparam logic [12:0] WORD_ZERO = 13'h0000;
    localparam logic [12:0] WORD_ONES = 13'h1FFF;
    localparam logic [12:0] WORD_CHK_A = 13'h1555;
    localparam logic [12:0] WORD_CHK_B = 13'h0AAA;
    localparam logic [11:0] ABP_MASK = 12'hAAA;
endpackage

// >>> src/aof_word_gen.sv
// output word generator: formatting and test pattern override
// assumes one sample strobe per encode clock and a settled format byte
`timescale 1ns/1ps
module aof_word_gen
    import aof_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] fmt,
    input wire logic sample_strobe,
    input wire logic overrange_in,
    input wire logic [DATA_W-1:0] sample_in,
    output logic word_valid_r,
    output logic overrange_flag_out_r,
    output logic [DATA_W-1:0] sample_bits_out_r
);
    logic phase_r;
    logic phase_nxt;
    logic word_valid_nxt;
    logic [WORD_W-1:0] word_r;
    logic [WORD_W-1:0] word_nxt;
    logic [DATA_W-1:0] fmt_data;
    logic [2:0] tp;
    logic [2:0] last_tp_r;
    logic [2:0] last_tp_nxt;
    logic phase_cur;

    assign tp = fmt[TP_LSB +: TP_W];

    // a pattern entered from any other code, even the other pattern, restarts at phase 0
    assign phase_cur = (tp == last_tp_r) ? phase_r : 1'b0;

    // data path; abp wins over two's complement so offset binary stays
    always_comb begin
        fmt_data = sample_in;
        if (fmt[TWOS_BIT] && !fmt[ABP_BIT]) begin // RULE8 RULE9
            fmt_data[DATA_W-1] = ~sample_in[DATA_W-1];
        end
        if (fmt[OUTPUT_SCRAMBLE_ENABLE_BIT]) begin // RULE7
            fmt_data[DATA_W-1:1] = fmt_data[DATA_W-1:1] ^ {(DATA_W-1){fmt_data[0]}};
        end
        if (fmt[ABP_BIT]) begin // RULE9
            fmt_data = fmt_data ^ ABP_MASK;
        end
    end

    // pattern override sits after formatting, words change only on strobe
    always_comb begin
        word_nxt = word_r;
        phase_nxt = phase_r;
        last_tp_nxt = last_tp_r;
        word_valid_nxt = sample_strobe;
        if (sample_strobe) begin
            case (tp)
                TP_ZERO: word_nxt = WORD_ZERO; // RULE2 RULE14
                TP_ONES: word_nxt = WORD_ONES; // RULE3 RULE14
                TP_CHECKER: word_nxt = phase_cur ? WORD_CHK_B : WORD_CHK_A; // RULE4
                TP_TOGGLE: word_nxt = phase_cur ? WORD_ONES : WORD_ZERO; // RULE5
                // unused codes fall back to live data rather than garbage
                default: word_nxt = {overrange_in, fmt_data}; // RULE1
            endcase
            phase_nxt = (tp == TP_CHECKER || tp == TP_TOGGLE) ? ~phase_cur : 1'b0;
            last_tp_nxt = tp;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            word_r <= WORD_ZERO;
            phase_r <= 1'b0;
            last_tp_r <= TP_OFF;
            word_valid_r <= 1'b0;
        end else begin
            word_r <= word_nxt;
            phase_r <= phase_nxt;
            last_tp_r <= last_tp_nxt;
            word_valid_r <= word_valid_nxt;
        end
    end

    assign overrange_flag_out_r = word_r[WORD_W-1];
    assign sample_bits_out_r = word_r[DATA_W-1:0];
endmodule

// >>> src/aof_formatter.sv
// top of the output formatting stage with its serial configuration port
// assumes cs_n, sck, sdi synchronous to ref_clk and sck slower than ref_clk/2
`timescale 1ns/1ps
module aof_formatter
    import aof_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    input wire logic sample_strobe,
    input wire logic overrange_in,
    input wire logic [DATA_W-1:0] sample_in,
    output logic word_valid,
    output logic overrange_flag_out,
    output logic [DATA_W-1:0] sample_bits_out,
    output logic [7:0] format_out
);
    logic sck_d_r;
    logic sck_d_nxt;
    logic sck_rise;
    logic sck_fall;
    logic [4:0] bit_cnt_r;
    logic [4:0] bit_cnt_nxt;
    logic [7:0] cmd_r;
    logic [7:0] cmd_nxt;
    logic [14:0] shift_r;
    logic [14:0] shift_nxt;
    logic [7:0] fmt_r;
    logic [7:0] fmt_nxt;
    logic sdo_oe_r;
    logic sdo_oe_nxt;
    logic sdo_out_r;
    logic [15:0] full_word;
    logic [7:0] rd_byte;
    logic word_valid_r;
    logic overrange_r;
    logic [DATA_W-1:0] bits_r;

    // read decode; the reset register is write only and reads zero
    function automatic logic [7:0] read_reg(input logic [6:0] addr, input logic [7:0] f);
        read_reg = (addr == ADDR_FORMAT) ? f : 8'h00;
    endfunction

    assign sck_rise = sck && !sck_d_r;
    assign sck_fall = !sck && sck_d_r;
    assign full_word = {shift_r, sdi};
    assign rd_byte = read_reg(cmd_r[6:0], fmt_r);

    // serial shifter: first sixteen rising edges count, the rest are ignored
    always_comb begin
        sck_d_nxt = sck;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        cmd_nxt = cmd_r;
        fmt_nxt = fmt_r;
        if (cs_n) begin
            bit_cnt_nxt = 5'h00;
        end else if (sck_rise && bit_cnt_r < SER_BITS) begin // RULE11
            shift_nxt = full_word[14:0];
            bit_cnt_nxt = bit_cnt_r + 5'h01;
            if (bit_cnt_r == SER_CMD_LAST) begin
                cmd_nxt = full_word[7:0];
            end
            if (bit_cnt_r == SER_BITS - 5'h01 && !full_word[15]) begin // RULE12
                if (full_word[14:8] == ADDR_RESET && full_word[RESET_BIT]) begin
                    fmt_nxt = FORMAT_RESET; // RULE13
                end else if (full_word[14:8] == ADDR_FORMAT) begin
                    fmt_nxt = full_word[7:0] & FORMAT_USED_MASK; // RULE10
                end
            end
        end
    end

    // readback on falling edges; open drain, so enable pulls the line low
    always_comb begin
        sdo_oe_nxt = sdo_oe_r;
        if (cs_n) begin
            sdo_oe_nxt = 1'b0;
        end else if (sck_fall && cmd_r[7] && bit_cnt_r[3] && !bit_cnt_r[4]) begin // RULE12
            sdo_oe_nxt = ~rd_byte[3'(~bit_cnt_r[2:0])];
        end else if (bit_cnt_r == SER_BITS && sck_fall) begin
            sdo_oe_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sck_d_r <= 1'b0;
            bit_cnt_r <= 5'h00;
            shift_r <= 15'h0000;
            cmd_r <= 8'h00;
            fmt_r <= FORMAT_RESET;
            sdo_oe_r <= 1'b0;
            sdo_out_r <= 1'b0;
        end else begin
            sck_d_r <= sck_d_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            cmd_r <= cmd_nxt;
            fmt_r <= fmt_nxt; // RULE15
            sdo_oe_r <= sdo_oe_nxt;
            sdo_out_r <= 1'b0;
        end
    end

    // the generator samples fmt_r, so a write lands on the following word
    aof_word_gen u_gen (
        .ref_clk(ref_clk),
        .srst(srst),
        .fmt(fmt_r), // RULE15
        .sample_strobe(sample_strobe),
        .overrange_in(overrange_in),
        .sample_in(sample_in),
        .word_valid_r(word_valid_r),
        .overrange_flag_out_r(overrange_r),
        .sample_bits_out_r(bits_r)
    );

    assign sdo_out = sdo_out_r;
    assign sdo_oe = sdo_oe_r;
    assign word_valid = word_valid_r;
    assign overrange_flag_out = overrange_r;
    assign sample_bits_out = bits_r;
    assign format_out = fmt_r;

    // checking helpers: previous word and the test code it was made with
    logic [WORD_W-1:0] prev_word_r;
    logic [2:0] prev_tp_r;
    logic [2:0] tp_now;
    assign tp_now = fmt_r[TP_LSB +: TP_W];
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prev_word_r <= WORD_ZERO;
            prev_tp_r <= TP_OFF;
        end else if (sample_strobe) begin
            prev_word_r <= {overrange_r, bits_r};
            prev_tp_r <= tp_now;
        end
    end

    sequence s_plain(logic t, logic r, logic a);
        sample_strobe && tp_now == TP_OFF && fmt_r[TWOS_BIT] == t
            && fmt_r[OUTPUT_SCRAMBLE_ENABLE_BIT] == r && fmt_r[ABP_BIT] == a;
    endsequence

    property p_off;
        @(posedge ref_clk) disable iff (srst)
        s_plain(1'b0, 1'b0, 1'b0) |=>
            {overrange_flag_out, sample_bits_out} == {$past(overrange_in), $past(sample_in)};
    endproperty
    a_off: assert property (p_off) else $error("data not passed through"); // RULE1

    property p_zero;
        @(posedge ref_clk) disable iff (srst)
        sample_strobe && tp_now == TP_ZERO |=> word_valid && !overrange_flag_out
            && sample_bits_out == 12'h000;
    endproperty
    a_zero: assert property (p_zero) else $error("zero pattern wrong"); // RULE2

    property p_ones;
        @(posedge ref_clk) disable iff (srst)
        sample_strobe && tp_now == TP_ONES |=> overrange_flag_out && sample_bits_out == 12'hFFF;
    endproperty
    a_ones: assert property (p_ones) else $error("ones pattern wrong"); // RULE3

    property p_checker;
        @(posedge ref_clk) disable iff (srst)
        sample_strobe && tp_now == TP_CHECKER |=>
            ({overrange_flag_out, sample_bits_out} == WORD_CHK_A
            || {overrange_flag_out, sample_bits_out} == WORD_CHK_B)
            && ($past(prev_tp_r) != TP_CHECKER
            || {overrange_flag_out, sample_bits_out} == ~prev_word_r);
    endproperty
    a_checker: assert property (p_checker) else $error("checkerboard wrong"); // RULE4

    property p_toggle;
        @(posedge ref_clk) disable iff (srst)
        sample_strobe && tp_now == TP_TOGGLE && prev_tp_r == TP_TOGGLE |=>
            {overrange_flag_out, sample_bits_out} == ~prev_word_r;
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle pattern wrong"); // RULE5

    property p_output_scramble_enable;
        @(posedge ref_clk) disable iff (srst)
        s_plain(1'b0, 1'b1, 1'b0) |=> sample_bits_out[0] == $past(sample_in[0])
            && sample_bits_out[11:1] == ($past(sample_in[11:1]) ^ {11{$past(sample_in[0])}});
    endproperty
    a_output_scramble_enable: assert property (p_output_scramble_enable) else $error("randomizer wrong"); // RULE7

    property p_twos;
        @(posedge ref_clk) disable iff (srst)
        s_plain(1'b1, 1'b0, 1'b0) |=> sample_bits_out == ($past(sample_in) ^ 12'h800);
    endproperty
    a_twos: assert property (p_twos) else $error("two's complement wrong"); // RULE8

    property p_abp;
        @(posedge ref_clk) disable iff (srst)
        sample_strobe && tp_now == TP_OFF && fmt_r[ABP_BIT] && !fmt_r[OUTPUT_SCRAMBLE_ENABLE_BIT]
            |=> sample_bits_out == ($past(sample_in) ^ ABP_MASK);
    endproperty
    a_abp: assert property (p_abp) else $error("polarity mode not offset binary"); // RULE9

    property p_unused;
        @(posedge ref_clk) disable iff (srst) fmt_r[7:6] == 2'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bits stored"); // RULE10

    sequence s_last_edge;
        !cs_n && sck_rise && bit_cnt_r == SER_BITS - 5'h01;
    endsequence

    property p_read_keeps;
        @(posedge ref_clk) disable iff (srst)
        s_last_edge and full_word[15] |=> fmt_r == $past(fmt_r);
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read changed register"); // RULE12

    property p_swreset;
        @(posedge ref_clk) disable iff (srst)
        s_last_edge and (full_word[15:8] == {1'b0, ADDR_RESET} && full_word[RESET_BIT])
            |=> fmt_r == FORMAT_RESET;
    endproperty
    a_swreset: assert property (p_swreset) else $error("software reset missed"); // RULE13

    property p_write;
        @(posedge ref_clk) disable iff (srst)
        s_last_edge and (full_word[15:8] == {1'b0, ADDR_FORMAT})
            |=> fmt_r == ($past(full_word[7:0]) & FORMAT_USED_MASK);
    endproperty
    a_write: assert property (p_write) else $error("format write lost"); // RULE11

    // a format write between strobes must not disturb the word on the pins
    property p_next_word;
        @(posedge ref_clk) disable iff (srst)
        !sample_strobe |=> !word_valid
            && $stable({overrange_flag_out, sample_bits_out});
    endproperty
    a_next_word: assert property (p_next_word) else $error("word changed between strobes"); // RULE15
endmodule

// >>> test/aof_capture.sv
// downstream capture model: latches each output word and counts them
// assumes word_valid is a one-cycle pulse on ref_clk
`timescale 1ns/1ps
module aof_capture
    import aof_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic word_valid,
    input wire logic overrange_flag_out,
    input wire logic [DATA_W-1:0] sample_bits_out,
    output logic [WORD_W-1:0] cap_word,
    output logic [15:0] cap_cnt
);
    // take the word on the pulse, like a plain register bank downstream
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cap_word <= '0;
            cap_cnt <= '0;
        end else if (word_valid) begin
            cap_word <= {overrange_flag_out, sample_bits_out};
            cap_cnt <= cap_cnt + 16'h0001;
        end
    end
endmodule

// >>> test/adc_output_data_formatter_test.sv
// self-checking bench for the output formatting stage
// assumes inputs change at the falling edge; sdo has a pull-up
`timescale 1ns/1ps
module adc_output_data_formatter_test
    import aof_pkg::*;
;
    logic ref_clk, srst, cs_n, sck, sdi, sdo_out, sdo_oe, sdo;
    logic sample_strobe, overrange_in, word_valid, overrange_flag_out;
    logic [DATA_W-1:0] sample_in, sample_bits_out;
    logic [7:0] format_out, rd, mf;
    logic [WORD_W-1:0] cap_word;
    logic [15:0] cap_cnt;
    logic [2:0] ltp;
    int mismatches, n_compared, seed, ph, nstr;
    // legal codes only, unused top bits set once
    logic [7:0] fl [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h28, 8'h04, 8'h38,
        8'h05, 8'h07, 8'h08, 8'hC3, 8'h18, 8'h2F, 8'h3A};
    aof_formatter DUT (.ref_clk(ref_clk), .srst(srst), .cs_n(cs_n), .sck(sck),
        .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sample_strobe(sample_strobe),
        .overrange_in(overrange_in), .sample_in(sample_in), .word_valid(word_valid),
        .overrange_flag_out(overrange_flag_out), .sample_bits_out(sample_bits_out),
        .format_out(format_out));
    aof_capture cap (.ref_clk(ref_clk), .srst(srst), .word_valid(word_valid),
        .overrange_flag_out(overrange_flag_out), .sample_bits_out(sample_bits_out),
        .cap_word(cap_word), .cap_cnt(cap_cnt));
    // open-drain line with pull-up
    assign sdo = sdo_oe ? sdo_out : 1'b1;
    always #12.5 ref_clk = ~ref_clk;
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic end_sim;
        if (mismatches == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // bit-banged serial word, msb first; short counts abort the word
    task automatic spi(input logic [15:0] w, input int nb, output logic [7:0] r);
        int i;
        cs_n = 0;
        r = '0;
        for (i = 0; i < nb; i++) begin
            sdi = w[15-i];
            sck = 0;
            repeat (2) @(negedge ref_clk);
            if (i >= 8) r[15-i] = sdo;
            sck = 1;
            repeat (2) @(negedge ref_clk);
        end
        cs_n = 1;
        sck = 0;
        sdi = ~sdi;
        repeat (2) @(negedge ref_clk);
    endtask
    // reference formatting: pattern override first, then sign flip, randomizer, polarity
    function automatic logic [12:0] ref_word(logic [7:0] f, logic ov, logic [11:0] d, int p);
        logic [11:0] x;
        x = d;
        case (f[5:3])
            TP_ZERO: return WORD_ZERO;
            TP_ONES: return WORD_ONES;
            TP_CHECKER: return p ? WORD_CHK_B : WORD_CHK_A;
            TP_TOGGLE: return p ? WORD_ONES : WORD_ZERO;
            default: ;
        endcase
        if (f[0] && !f[2]) x[11] = ~x[11];
        if (f[1]) x[11:1] = x[11:1] ^ {11{x[0]}};
        if (f[2]) x = x ^ ABP_MASK;
        return {ov, x};
    endfunction
    // back-to-back strobes with random samples, each result checked next cycle
    task automatic run(input int n);
        logic [12:0] e;
        int i;
        for (i = 0; i <= n; i++) begin
            if (i > 0) begin
                chk(word_valid, 1);
                chk({overrange_flag_out, sample_bits_out}, e);
            end
            if (i < n) begin
                {overrange_in, sample_in} = 13'($random(seed));
                sample_strobe = 1;
                if (mf[5:3] != ltp) ph = 0;
                e = ref_word(mf, overrange_in, sample_in, ph);
                ph ^= 1;
                ltp = mf[5:3];
                nstr++;
            end else sample_strobe = 0;
            @(negedge ref_clk);
        end
        chk(word_valid, 0);
        chk(cap_word, e);
    endtask
    initial begin
        #1000000;
        mismatches++;
        end_sim;
    end
    initial begin
        ref_clk = 0; srst = 1; cs_n = 1; sck = 0; sdi = 0;
        sample_strobe = 0; overrange_in = 0; sample_in = '0;
        seed = 32'h90f0; ph = 0; ltp = 3'h0; nstr = 0; mf = 8'h00;
        repeat (10) @(negedge ref_clk);
        srst = 0;
        chk(format_out, FORMAT_RESET);
        foreach (fl[k]) begin
            spi({1'b0, ADDR_FORMAT, fl[k]}, 16, rd);
            mf = fl[k] & FORMAT_USED_MASK;
            chk(format_out, mf);
            spi({1'b1, ADDR_FORMAT, 8'hC5}, 16, rd);
            chk(rd, mf);
            chk(format_out, mf);
            run(5);
        end
        spi({1'b0, 7'h05, 8'h00}, 16, rd);
        chk(format_out, mf);
        spi({1'b1, 7'h05, 8'h00}, 16, rd);
        chk(rd, 8'h00);
        spi({1'b0, ADDR_FORMAT, 8'h01}, 12, rd);
        chk(format_out, mf);
        spi({1'b0, ADDR_RESET, 8'h80}, 16, rd);
        mf = 8'h00;
        chk(format_out, mf);
        run(4);
        chk(cap_cnt, 16'(nstr));
        end_sim;
    end
endmodule
